/* design/ldsi_pkg.sv */
// package: constants for the logical destination and self-interrupt block
`default_nettype none
package ldsi_pkg;
  // ---------------------------------------------------------------
  // model register addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] LOGICAL_DEST_ADDR = 32'h0000080D;
  localparam logic [31:0] SELF_INT_ADDR = 32'h0000083F;
  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int CLUSTER_LSB = 16;
  localparam int PHYS_CLUSTER_LSB = 4;
  localparam int CLUSTER_BITS = 16;
  localparam int MEMBER_SEL_BITS = 4;
  localparam logic [7:0] LAST_ILLEGAL_VECTOR = 8'h0F;
  // implemented width of cluster field; upper unimplemented bits read zero
  localparam int CLUSTER_IMPL_BITS = 16;
  // ---------------------------------------------------------------
  // command-register equivalent of a self interrupt, and logical destination reset value
  // ---------------------------------------------------------------
  localparam logic [1:0] SHORTHAND_SELF = 2'h1;
  localparam logic [2:0] DELIVERY_FIXED = 3'h0;
  localparam logic TRIGGER_EDGE = 1'b0;
  localparam logic [31:0] LOGICAL_DEST_RESET = 32'h00000000;
  // ---------------------------------------------------------------
  // states of the mode-entry loader
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LDSI_LEGACY = 2'b00,
    LDSI_LOAD = 2'b01,
    LDSI_EXT = 2'b11
  } ldsi_mode_t;
endpackage : ldsi_pkg
`default_nettype wire

/* design/ldsi_vector_check.sv */
// module: vector legality check and self-interrupt command fields
`timescale 1ns/1ns
`default_nettype none
module ldsi_vector_check (
  input wire logic [7:0] vector,
  output logic legal,
  output logic [1:0] shorthand,
  output logic [2:0] delivery,
  output logic trigger
);
  import ldsi_pkg::*;
  // vectors 00..0F are reserved for exceptions and never delivered
  assign legal = (vector > LAST_ILLEGAL_VECTOR);
  assign shorthand = SHORTHAND_SELF;
  assign delivery = DELIVERY_FIXED;
  assign trigger = TRIGGER_EDGE;
endmodule : ldsi_vector_check
`default_nettype wire

/* design/ldsi_logical_dest.sv */
// module: logical destination register and self-interrupt register
//
// What this block does
// [R1] logical destination is 32 bits, read only, at model address 80D
// [R2] only clustered logical addressing; no destination format register exists
// [R3] cluster in bits 31:16, member in bits 15:0
// [R4] unimplemented cluster or member bits read as zero
// [R5] member field is one shifted left by physical id bits 3:0
// [R6] cluster field comes from physical id bits 19:4
// [R7] register reloaded from physical id whenever extended mode is enabled
// [R8] self write acts as fixed, edge, self-shorthand command with that vector
// [R9] self register is write only; reading it faults
// [R10] self interrupt goes through request and trigger-mode tracking
// [R11] request bit is set by the time the write completes
// [R12] same-vector edge interrupts may merge into one pending request
// [R13] software masks low sixteen bits for member address
// [R14] software ORs ids of same cluster for a cluster destination
// [R15] self write with vector 0F or below sets send-illegal error
// [R16] received vector 0F or below is dropped and sets receive-illegal error
// [R17] write to logical destination faults and changes nothing
`timescale 1ns/1ns
`default_nettype none
module ldsi_logical_dest (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic extModeEn,
  input wire logic [31:0] physId,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regDone,
  output logic gpFault,
  input wire logic rxValid,
  input wire logic [7:0] rxVector,
  output logic [255:0] requestBits,
  output logic [255:0] triggerBits,
  output logic sendIllegal,
  output logic rxIllegal,
  output logic [31:0] logicalDest
);
  import ldsi_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // derive the logical id from a physical id
  function automatic logic [31:0] derive_logical(input logic [31:0] pid);
    logic [31:0] v;
    v = 32'h00000000;
    v[CLUSTER_LSB +: CLUSTER_BITS] = pid[PHYS_CLUSTER_LSB +: CLUSTER_BITS]; // [R6] [R3]
    v[15:0] = 16'h0001 << pid[MEMBER_SEL_BITS-1:0]; // [R5]
    // cluster bits above the implemented width are cleared
    for (int i = CLUSTER_LSB + CLUSTER_IMPL_BITS; i < 32; i++) begin
      v[i] = 1'b0; // [R4]
    end
    return v;
  endfunction : derive_logical

  function automatic logic [255:0] one_hot256(input logic [7:0] vec);
    return 256'h1 << vec;
  endfunction : one_hot256

  // ---------------------------------------------------------------
  // mode tracking and loading
  // ---------------------------------------------------------------
  ldsi_mode_t modeState;
  ldsi_mode_t next_modeState;
  logic extModeSync1, extModeSync2;

  // mode enable comes from the base register of another domain path; synchronise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      extModeSync1 <= 1'b0;
      extModeSync2 <= 1'b0;
    end else begin
      extModeSync1 <= extModeEn;
      extModeSync2 <= extModeSync1;
    end
  end

  // load once per rising entry into extended mode
  always_comb begin
    next_modeState = modeState;
    case (modeState)
      LDSI_LEGACY: if (extModeSync2) next_modeState = LDSI_LOAD;
      LDSI_LOAD: next_modeState = extModeSync2 ? LDSI_EXT : LDSI_LEGACY;
      LDSI_EXT: if (!extModeSync2) next_modeState = LDSI_LEGACY;
      default: next_modeState = LDSI_LEGACY;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) modeState <= LDSI_LEGACY;
    else modeState <= next_modeState;
  end

  // register holds its value; no write path exists from software
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      logicalDest <= LOGICAL_DEST_RESET;
    end else if (modeState == LDSI_LOAD) begin
      logicalDest <= derive_logical(physId); // [R7]
    end
  end

  // ---------------------------------------------------------------
  // model register access decode
  // ---------------------------------------------------------------
  logic inExt;
  logic selfWrite;
  logic [7:0] selfVector;
  logic vecLegal, rxLegal;
  logic [1:0] cmdShorthand;
  logic [2:0] cmdDelivery;
  logic cmdTrigger;

  // accesses only count once the loader has settled in extended mode
  assign inExt = (modeState == LDSI_EXT);
  assign selfWrite = inExt && regWrite && (regAddr == SELF_INT_ADDR);
  assign selfVector = regWrData[7:0];

  ldsi_vector_check selfCheck (
    .vector(selfVector),
    .legal(vecLegal),
    .shorthand(cmdShorthand),
    .delivery(cmdDelivery),
    .trigger(cmdTrigger)
  );

  ldsi_vector_check rxCheck (
    .vector(rxVector),
    .legal(rxLegal),
    .shorthand(),
    .delivery(),
    .trigger()
  );

  // read data and fault answer one cycle after the access
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 32'h00000000;
      regDone <= 1'b0;
      gpFault <= 1'b0;
    end else begin
      regDone <= inExt && (regRead || regWrite);
      regRdData <= 32'h00000000;
      gpFault <= 1'b0;
      if (inExt && regRead) begin
        if (regAddr == LOGICAL_DEST_ADDR) regRdData <= logicalDest; // [R1]
        else if (regAddr == SELF_INT_ADDR) gpFault <= 1'b1; // [R9]
      end
      // no format register: its legacy address is simply unmapped here [R2]
      if (inExt && regWrite && regAddr == LOGICAL_DEST_ADDR) gpFault <= 1'b1; // [R17]
    end
  end

  // ---------------------------------------------------------------
  // request and trigger-mode tracking
  // ---------------------------------------------------------------
  logic selfPost;
  logic rxPost;
  // fixed delivery to self is the only form this path can post
  assign selfPost = selfWrite && vecLegal && cmdShorthand == SHORTHAND_SELF
                    && cmdDelivery == DELIVERY_FIXED; // [R8]
  assign rxPost = rxValid && rxLegal;

  // set lands on the same edge that completes the write and raises regDone
  // an already pending bit just stays set, so identical vectors merge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      requestBits <= '0;
      triggerBits <= '0;
    end else begin
      if (selfPost) begin
        requestBits <= requestBits | one_hot256(selfVector); // [R10] [R11] [R12]
        triggerBits <= cmdTrigger ? (triggerBits | one_hot256(selfVector))
                                  : (triggerBits & ~one_hot256(selfVector)); // [R10]
      end else if (rxPost) begin
        requestBits <= requestBits | one_hot256(rxVector); // [R16]
      end
    end
  end

  // error pulses feed the error status register of the unit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sendIllegal <= 1'b0;
      rxIllegal <= 1'b0;
    end else begin
      sendIllegal <= selfWrite && !vecLegal; // [R15]
      rxIllegal <= rxValid && !rxLegal; // [R16]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ldr_derive: assert property (@(posedge mclk) disable iff (!arst_n)
    modeState == LDSI_LOAD |=> logicalDest == derive_logical($past(physId)))
    else $error("logical id not derived from physical id"); // [R7]
  a_member_onehot: assert property (@(posedge mclk) disable iff (!arst_n)
    modeState == LDSI_EXT |-> $onehot(logicalDest[15:0]))
    else $error("member field not one hot"); // [R5]
  a_ldr_readonly: assert property (@(posedge mclk) disable iff (!arst_n)
    modeState == LDSI_EXT && $past(modeState) == LDSI_EXT |-> $stable(logicalDest))
    else $error("logical id changed while in extended mode"); // [R17]
  a_ldr_read: assert property (@(posedge mclk) disable iff (!arst_n)
    inExt && regRead && regAddr == LOGICAL_DEST_ADDR |=> regRdData == logicalDest && !gpFault)
    else $error("logical id read wrong"); // [R1]
  a_self_read_fault: assert property (@(posedge mclk) disable iff (!arst_n)
    inExt && regRead && regAddr == SELF_INT_ADDR |=> gpFault && regRdData == 32'h00000000)
    else $error("self register read did not fault"); // [R9]
  a_ldr_wr_fault: assert property (@(posedge mclk) disable iff (!arst_n)
    inExt && regWrite && regAddr == LOGICAL_DEST_ADDR |=> gpFault)
    else $error("logical id write did not fault"); // [R17]
  a_self_posted: assert property (@(posedge mclk) disable iff (!arst_n)
    selfWrite && selfVector > LAST_ILLEGAL_VECTOR
    |=> requestBits[$past(selfVector)] && !triggerBits[$past(selfVector)] && regDone)
    else $error("self interrupt not pending at completion"); // [R11]
  a_send_illegal: assert property (@(posedge mclk) disable iff (!arst_n)
    selfWrite && selfVector <= LAST_ILLEGAL_VECTOR
    |=> sendIllegal && requestBits == $past(requestBits))
    else $error("illegal self vector not flagged"); // [R15]
  a_rx_illegal: assert property (@(posedge mclk) disable iff (!arst_n)
    rxValid && rxVector <= LAST_ILLEGAL_VECTOR && !selfWrite
    |=> rxIllegal && requestBits == $past(requestBits))
    else $error("illegal received vector delivered"); // [R16]
  a_cluster_field: assert property (@(posedge mclk) disable iff (!arst_n)
    modeState == LDSI_LOAD |=> logicalDest[31:16] == $past(physId[19:4]))
    else $error("cluster field wrong"); // [R6]
endmodule : ldsi_logical_dest
`default_nettype wire

/* verification/ldsi_logical_dest_tb.sv */
// testbench: logical destination and self-interrupt block, random and corner cases
`timescale 1ns/1ns
`default_nettype none
module ldsi_logical_dest_tb;
  import ldsi_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0, arst_n = 1'b0, extModeEn = 1'b0, regRead = 1'b0, regWrite = 1'b0;
  logic rxValid = 1'b0;
  logic [31:0] physId = 32'h0, regAddr = 32'h0, regWrData = 32'h0;
  logic [7:0] rxVector = 8'h00;
  logic [31:0] regRdData, logicalDest, gotData, seed = 32'h20, expLd, r;
  logic regDone, gpFault, sendIllegal, rxIllegal, gotDone, gotFault, gotIll;
  logic [255:0] requestBits, triggerBits, expReq = 256'h0;
  logic [7:0] v;
  int n_errors = 0, cmp_count = 0, cycles = 0;
  ldsi_logical_dest ldsi_logical_dest_i (.mclk(mclk), .arst_n(arst_n), .extModeEn(extModeEn),
    .physId(physId), .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regDone(regDone), .gpFault(gpFault),
    .rxValid(rxValid), .rxVector(rxVector), .requestBits(requestBits),
    .triggerBits(triggerBits), .sendIllegal(sendIllegal), .rxIllegal(rxIllegal),
    .logicalDest(logicalDest));
  always #25 mclk = ~mclk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // xorshift keeps the run repeatable without a simulator seed
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // expected id: cluster from id bits 19:4, one-hot member from bits 3:0
  function automatic logic [31:0] ld_of(input logic [31:0] p);
    return {p[19:4], 16'h0001 << p[3:0]};
  endfunction : ld_of
  task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  // one request pulse, then a bounded wait for the completion pulse
  task automatic access(input logic rd, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(negedge mclk);
    regRead = rd; regWrite = !rd; regAddr = a; regWrData = d;
    @(negedge mclk);
    regRead = 1'b0; regWrite = 1'b0;
    gotDone = 1'b0; gotFault = 1'b0; gotIll = 1'b0; gotData = 32'h0;
    for (k = 0; k < 3 && !gotDone; k++) begin
      gotIll = gotIll | (sendIllegal === 1'b1);
      if (regDone === 1'b1) begin
        gotDone = 1'b1; gotFault = gpFault; gotData = regRdData;
      end else begin
        @(negedge mclk);
      end
    end
  endtask : access
  task automatic rx(input logic [7:0] vec);
    @(negedge mclk);
    rxValid = 1'b1; rxVector = vec;
    @(negedge mclk);
    rxValid = 1'b0;
    gotIll = (rxIllegal === 1'b1);
    @(negedge mclk);
    gotIll = gotIll | (rxIllegal === 1'b1);
  endtask : rx
  task automatic enter_mode(input logic [31:0] p);
    physId = p; extModeEn = 1'b1;
    repeat (5) @(negedge mclk);
  endtask : enter_mode
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    chk(logicalDest, 0, "reset value");
    access(1'b1, LOGICAL_DEST_ADDR, 32'h0);
    chk(gotDone, 0, "legacy access answered");
    $display("test legacy done");
    // corner ids: all ones above bit 19, zero, then random
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : xs();
      expLd = ld_of(r);
      enter_mode(r);
      chk(logicalDest, expLd, "loaded id");
      access(1'b1, LOGICAL_DEST_ADDR, 32'h0);
      chk({gotDone, gotFault, gotData}, {2'b10, expLd}, "id read");
      chk(gotData & 32'h0000FFFF, 32'h1 << r[3:0], "member by mask");
      chk(logicalDest | ld_of(r ^ 32'h1), {r[19:4], 16'h0003 << {r[3:1], 1'b0}},
        "cluster or");
      access(1'b0, LOGICAL_DEST_ADDR, ~expLd);
      chk({gotDone, gotFault, logicalDest}, {2'b11, expLd}, "id write");
      if (i < 3) begin
        extModeEn = 1'b0;
        repeat (4) @(negedge mclk);
      end
    end
    $display("test logical id done");
    access(1'b1, SELF_INT_ADDR, 32'h0);
    chk({gotDone, gotFault}, 2'b11, "self read");
    access(1'b1, LOGICAL_DEST_ADDR + 32'h1, 32'h0);
    chk({gotDone, gotFault, gotData}, {2'b10, 32'h0}, "no format reg");
    $display("test faults done");
    // legal self posts, with a repeated vector that must merge
    for (int i = 0; i < 10; i++) begin
      r = xs();
      v = (i == 0 || i == 1) ? 8'h10 : (i == 2) ? 8'hFF : 8'h10 + 8'(r[7:0] % 8'd240);
      expReq[v] = 1'b1;
      access(1'b0, SELF_INT_ADDR, {r[31:8], v});
      chk({gotDone, gotFault, gotIll}, 3'b100, "self post");
      chk(requestBits, expReq, "request after post");
      chk(triggerBits[v], TRIGGER_EDGE, "edge trigger");
    end
    for (int j = 0; j < 2; j++) begin
      access(1'b0, SELF_INT_ADDR, {24'h0, (j == 0) ? 8'h00 : LAST_ILLEGAL_VECTOR});
      chk({gotDone, gotFault, gotIll}, 3'b101, "illegal self flag");
      chk(requestBits, expReq, "illegal self post");
    end
    $display("test self post done");
    for (int i = 0; i < 3; i++) begin
      r = xs();
      v = (i == 0) ? 8'h05 : (i == 1) ? LAST_ILLEGAL_VECTOR : 8'h10 + 8'(r[7:0] % 8'd240);
      if (i == 2) expReq[v] = 1'b1;
      rx(v);
      chk(gotIll, 1'(i < 2), "receive flag");
      chk(requestBits, expReq, "receive");
    end
    $display("test receive done");
    test_done();
  end
endmodule : ldsi_logical_dest_tb
`default_nettype wire
